// ### inc/emb_pkg.sv
// Purpose: constants shared by the external memory bus interface
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes:   phase lengths are counted in core clock cycles
package emb_pkg;

  // -----------------------------------------------------------------
  // address widths
  // -----------------------------------------------------------------
  localparam int CODE_AW          = 16;           // full code address, 64 kBytes
  localparam int DATA_AW          = 24;           // page:high:low, 16 MBytes
  localparam logic [15:0] RESET_VECTOR = 16'h0000; // start address in either space

  // -----------------------------------------------------------------
  // phase timing, cycles at 250 MHz
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 4;
  localparam int ADDR_SETUP_NS    = 8;            // address on port before strobe
  localparam int STROBE_NS        = 16;           // latch strobe width
  localparam int HOLD_NS          = 8;            // address held after strobe falls
  localparam int ACCESS_NS        = 40;           // fetch / read / write strobe width
  localparam int ADDR_SETUP_CYC   = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC       = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC         = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC       = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // -----------------------------------------------------------------
  // bus cycle states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    EMB_IDLE,       // no bus cycle, ports released
    EMB_ADDR,       // low address on low port, strobe low
    EMB_LATCH,      // latch strobe high
    EMB_HOLD,       // strobe low, address still driven
    EMB_ACCESS,     // fetch / read / write strobe active
    EMB_DONE        // answer pulse, strobes released
  } emb_state_t;

endpackage

// ### design/emb_phase_timer.sv
// Purpose: down counter that times one bus phase
// Assumes: load and tick never needed in the same cycle as expiry check issue
// Notes:   expired is high in the last cycle of the loaded count and stays high at zero
`timescale 1ns/10ps
module emb_phase_timer (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   load,
  input  wire logic [emb_pkg::CNT_W-1:0] load_val,
  output logic                        expired
);

  // -----------------------------------------------------------------
  // counter
  // -----------------------------------------------------------------
  logic [emb_pkg::CNT_W-1:0] cnt_r;  // cycles still to run

  // load wins over the running count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= emb_pkg::CNT_ZERO;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != emb_pkg::CNT_ZERO) begin
      cnt_r <= cnt_r - emb_pkg::CNT_ONE;
    end
  end

  // expiry when one cycle left, so a phase lasts exactly load_val cycles
  assign expired = (cnt_r == emb_pkg::CNT_ONE) || (cnt_r == emb_pkg::CNT_ZERO);

endmodule // emb_phase_timer

// ### design/emb_bus_if.sv
// Purpose: multiplexed external code and data memory bus engine
// Assumes: core issues one request at a time and waits for done
// Notes:   code fetches and data accesses share both ports
`timescale 1ns/10ps

module emb_bus_if (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // strap and core side
  input  wire logic        ext_code_select,      // high: run from internal code
  output logic             boot_from_external,   // registered strap decision
  output logic [15:0]      boot_vector,          // start address after reset
  input  wire logic        fetch_req,            // code fetch request, level until done
  input  wire logic [15:0] fetch_addr,           // program counter
  input  wire logic        data_req,             // data access request, level until done
  input  wire logic        data_write,           // 1 write, 0 read
  input  wire logic [23:0] data_addr,            // page:high:low pointer
  input  wire logic [7:0]  data_wdata,           // write byte
  output logic             done,                 // one-cycle answer
  output logic [7:0]       rdata,                // code or read byte
  output logic             bus_busy,             // ports owned by the bus
  output logic             gpio_allowed,         // ports free for general use
  // pins
  input  wire logic [7:0]  low_mux_port_in,
  output logic [7:0]       low_mux_port_out,
  output logic             low_mux_port_oe,
  output logic [7:0]       high_addr_port_out,
  output logic             high_addr_port_oe,
  output logic             addr_latch_strobe,
  output logic             code_fetch_strobe_n,
  output logic             rd_strobe_n,
  output logic             wr_strobe_n
);

  // -----------------------------------------------------------------
  // state and captured request
  // -----------------------------------------------------------------
  emb_pkg::emb_state_t state_r;        // bus cycle phase
  emb_pkg::emb_state_t state_nxt;      // next phase
  logic                is_code_r;      // cycle is a code fetch
  logic                is_write_r;     // data cycle is a write
  logic [23:0]         addr_r;         // captured address, code uses low 16
  logic [7:0]          wdata_r;        // captured write byte
  logic                strap_done_r;   // strap sampled once after reset
  logic                tmr_load;       // restart phase timer
  logic [emb_pkg::CNT_W-1:0] tmr_val;  // phase length
  logic                tmr_exp;        // phase over

  emb_phase_timer u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_exp)
  );

  // -----------------------------------------------------------------
  // strap sampling, taken by a clocked process after reset release
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_done_r       <= 1'b0;
      boot_from_external <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r       <= 1'b1;
      boot_from_external <= !ext_code_select;
    end
  end

  // both spaces begin at address zero
  assign boot_vector = emb_pkg::RESET_VECTOR;

  // -----------------------------------------------------------------
  // phase sequencer
  // -----------------------------------------------------------------
  // data wins arbitration only when no fetch waits; the core serialises
  // anyway, so this just fixes a priority for simultaneous requests
  always_comb begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_val   = emb_pkg::CNT_ZERO;
    unique case (state_r)
      emb_pkg::EMB_IDLE: begin
        if (fetch_req || data_req) begin
          state_nxt = emb_pkg::EMB_ADDR;
          tmr_load  = 1'b1;
          tmr_val   = emb_pkg::CNT_W'(emb_pkg::ADDR_SETUP_CYC);
        end
      end
      emb_pkg::EMB_ADDR: begin
        if (tmr_exp) begin
          state_nxt = emb_pkg::EMB_LATCH;
          tmr_load  = 1'b1;
          tmr_val   = emb_pkg::CNT_W'(emb_pkg::STROBE_CYC);
        end
      end
      emb_pkg::EMB_LATCH: begin
        if (tmr_exp) begin
          state_nxt = emb_pkg::EMB_HOLD;
          tmr_load  = 1'b1;
          tmr_val   = emb_pkg::CNT_W'(emb_pkg::HOLD_CYC);
        end
      end
      emb_pkg::EMB_HOLD: begin
        if (tmr_exp) begin
          state_nxt = emb_pkg::EMB_ACCESS;
          tmr_load  = 1'b1;
          tmr_val   = emb_pkg::CNT_W'(emb_pkg::ACCESS_CYC);
        end
      end
      emb_pkg::EMB_ACCESS: begin
        if (tmr_exp) begin
          state_nxt = emb_pkg::EMB_DONE;
        end
      end
      emb_pkg::EMB_DONE: begin
        state_nxt = emb_pkg::EMB_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= emb_pkg::EMB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // -----------------------------------------------------------------
  // request capture
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      is_code_r  <= 1'b0;
      is_write_r <= 1'b0;
      addr_r     <= 24'h000000;
      wdata_r    <= 8'h00;
    end else if (state_r == emb_pkg::EMB_IDLE && (fetch_req || data_req)) begin
      is_code_r  <= fetch_req;
      is_write_r <= !fetch_req && data_write;
      // code addresses keep all 16 bits, page forced to zero
      addr_r     <= fetch_req ? {8'h00, fetch_addr} : data_addr;
      wdata_r    <= data_wdata;
    end
  end

  // -----------------------------------------------------------------
  // pin drivers, all registered
  // -----------------------------------------------------------------
  logic in_addr;  // address phases before the access strobe
  assign in_addr = (state_nxt == emb_pkg::EMB_ADDR) || (state_nxt == emb_pkg::EMB_LATCH)
                   || (state_nxt == emb_pkg::EMB_HOLD);

  // low port: address, then float for code/read, or write data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_mux_port_out <= 8'h00;
      low_mux_port_oe  <= 1'b0;
    end else if (in_addr) begin
      low_mux_port_out <= (state_r == emb_pkg::EMB_IDLE)
                          ? (fetch_req ? fetch_addr[7:0] : data_addr[7:0]) : addr_r[7:0];
      low_mux_port_oe  <= 1'b1;
    end else if (state_nxt == emb_pkg::EMB_ACCESS && is_write_r) begin
      low_mux_port_out <= wdata_r;
      low_mux_port_oe  <= 1'b1;
    end else begin
      low_mux_port_oe  <= 1'b0;
    end
  end

  // high port: page byte while latched for data, then high byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_addr_port_out <= 8'h00;
      high_addr_port_oe  <= 1'b0;
    end else if (in_addr && state_r == emb_pkg::EMB_IDLE) begin
      high_addr_port_out <= fetch_req ? fetch_addr[15:8] : data_addr[23:16];
      high_addr_port_oe  <= 1'b1;
    end else if (state_nxt == emb_pkg::EMB_ACCESS) begin
      // page byte is ignored by systems without a page latch
      high_addr_port_out <= addr_r[15:8];
      high_addr_port_oe  <= 1'b1;
    end else if (state_nxt == emb_pkg::EMB_IDLE) begin
      high_addr_port_oe  <= 1'b0;
    end
  end

  // strobes: latch pulse mid-address, then the access strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_latch_strobe   <= 1'b0;
      code_fetch_strobe_n <= 1'b1;
      rd_strobe_n         <= 1'b1;
      wr_strobe_n         <= 1'b1;
    end else begin
      addr_latch_strobe   <= (state_nxt == emb_pkg::EMB_LATCH);
      code_fetch_strobe_n <= !(state_nxt == emb_pkg::EMB_ACCESS && is_code_r);
      rd_strobe_n         <= !(state_nxt == emb_pkg::EMB_ACCESS && !is_code_r && !is_write_r);
      wr_strobe_n         <= !(state_nxt == emb_pkg::EMB_ACCESS && !is_code_r && is_write_r);
    end
  end

  // -----------------------------------------------------------------
  // answer: byte sampled in the last access cycle, before strobe rises
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (state_r == emb_pkg::EMB_ACCESS && tmr_exp && !is_write_r) begin
      rdata <= low_mux_port_in;
    end
  end

  assign done         = (state_r == emb_pkg::EMB_DONE);
  // port ownership: general-purpose use only with no bus cycle running
  assign bus_busy     = (state_r != emb_pkg::EMB_IDLE);
  assign gpio_allowed = !boot_from_external && !bus_busy;

endmodule // emb_bus_if

// ### bench/emb_bus_props.sv
// Purpose: pin-level checks on the external bus engine
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to emb_bus_if below the module
`timescale 1ns/10ps
module emb_bus_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        boot_from_external,
  input wire logic [15:0] boot_vector,
  input wire logic        done,
  input wire logic        bus_busy,
  input wire logic        gpio_allowed,
  input wire logic [7:0]  low_mux_port_out,
  input wire logic        low_mux_port_oe,
  input wire logic        high_addr_port_oe,
  input wire logic        addr_latch_strobe,
  input wire logic        code_fetch_strobe_n,
  input wire logic        rd_strobe_n,
  input wire logic        wr_strobe_n
);
  // ----------------------------------------
  // strobe sequences and checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic acc_on = !code_fetch_strobe_n || !rd_strobe_n || !wr_strobe_n; // any access strobe
  sequence latch_pulse;
    $rose(addr_latch_strobe) ##0 addr_latch_strobe [*4] ##1 !addr_latch_strobe;
  endsequence
  sequence access_phase;
    acc_on [*8];
  endsequence
  boot_zero_a: assert property (boot_vector == 16'h0000) else $error("start address not zero");
  bus_owns_a: assert property (low_mux_port_oe || high_addr_port_oe || addr_latch_strobe || acc_on
    |-> bus_busy && !gpio_allowed) else $error("port freed while driven");
  latch_width_a: assert property ($rose(addr_latch_strobe) |-> latch_pulse) else $error("latch width");
  latch_addr_a: assert property (addr_latch_strobe |-> low_mux_port_oe && high_addr_port_oe)
    else $error("address not driven at latch");
  latch_then_acc_a: assert property (latch_pulse |-> ##[1:4] access_phase) else $error("no access");
  read_float_a: assert property (!code_fetch_strobe_n || !rd_strobe_n
    |-> !low_mux_port_oe && high_addr_port_oe) else $error("port not floated on read");
  wr_hold_a: assert property (!wr_strobe_n && !$past(wr_strobe_n)
    |-> low_mux_port_oe && $stable(low_mux_port_out)) else $error("write data moved");
  one_strobe_a: assert property ($onehot0({addr_latch_strobe, !code_fetch_strobe_n, !rd_strobe_n, !wr_strobe_n}))
    else $error("strobes overlap");
  done_time_a: assert property ($rose(bus_busy) |-> ##18 done) else $error("cycle length wrong");
endmodule // emb_bus_props

bind emb_bus_if emb_bus_props i_emb_bus_props (.clk, .rst_n, .boot_from_external, .boot_vector, .done,
  .bus_busy, .gpio_allowed, .low_mux_port_out, .low_mux_port_oe, .high_addr_port_oe, .addr_latch_strobe,
  .code_fetch_strobe_n, .rd_strobe_n, .wr_strobe_n);

// ### bench/emb_mem_model.sv
// Purpose: external code memory, data memory and address latches
// Assumes: strobes as driven by emb_bus_if
// Notes:   a released port shows the inverse of its last level
`timescale 1ns/10ps
module emb_mem_model #(parameter bit HAS_PAGE = 1'b1) (
  input  wire logic       clk,
  input  wire logic [7:0] low_out,
  input  wire logic       low_oe,
  input  wire logic [7:0] high_out,
  input  wire logic       adr_stb,
  input  wire logic       fetch_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic [7:0]      low_in,
  output logic [23:0]     wr_addr,
  output logic [7:0]      wr_data
);
  // ----------------------------------------
  // latches and memory answer
  // ----------------------------------------
  logic [7:0]  lat_low_r;   // low address latch
  logic [7:0]  lat_page_r;  // page latch
  logic [7:0]  last_r;      // last wire level
  logic [23:0] addr;        // latched full address
  // without a page latch the page byte is lost
  assign addr = {HAS_PAGE ? lat_page_r : 8'h00, high_out, lat_low_r};
  // latches follow the port while the strobe is high
  always @(posedge clk) begin
    if (adr_stb) begin
      lat_low_r <= low_out;
      lat_page_r <= high_out;
    end
    if (!wr_n) begin
      wr_addr <= addr;
      wr_data <= low_out;
    end
    last_r <= low_in;
  end
  // wire level: device, memory answer, or a drifting float
  always_comb begin
    if (low_oe) low_in = low_out;
    else if (!fetch_n) low_in = high_out ^ lat_low_r ^ 8'hA5;
    else if (!rd_n) low_in = addr[23:16] + high_out + lat_low_r;
    else low_in = ~last_r;
  end
endmodule // emb_mem_model

// ### bench/emb_bus_if_tb.sv
// Purpose: self-checking bench for emb_bus_if
// Assumes: inputs change on the falling edge
// Notes:   memory bytes are fixed functions of the address
`timescale 1ns/10ps
module emb_bus_if_tb;
  // ----------------------------------------
  // stimulus, model and scenarios
  // ----------------------------------------
  logic        clk = 1'b0, rst_n = 1'b0, sel = 1'b1, freq = 1'b0, dreq = 1'b0, dwr = 1'b0;
  logic [15:0] faddr = 16'h0000, bvec;
  logic [23:0] daddr = 24'h000000, wr_addr, np_addr;
  logic [7:0]  wdata = 8'h00, rdata, lo_in, lo_out, hi_out, wr_data;
  logic        boot_ext, done, busy, gpio, lo_oe, hi_oe, adr_stb, fetch_n, rd_n, wr_n;
  int          error_cnt = 0, checked = 0;
  always #2 clk = ~clk;
  emb_bus_if i_emb_bus_if (.clk, .rst_n, .ext_code_select(sel), .boot_from_external(boot_ext),
    .boot_vector(bvec), .fetch_req(freq), .fetch_addr(faddr), .data_req(dreq), .data_write(dwr),
    .data_addr(daddr), .data_wdata(wdata), .done, .rdata, .bus_busy(busy), .gpio_allowed(gpio),
    .low_mux_port_in(lo_in), .low_mux_port_out(lo_out), .low_mux_port_oe(lo_oe),
    .high_addr_port_out(hi_out), .high_addr_port_oe(hi_oe), .addr_latch_strobe(adr_stb),
    .code_fetch_strobe_n(fetch_n), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n));
  emb_mem_model i_emb_mem_model (.clk, .low_out(lo_out), .low_oe(lo_oe), .high_out(hi_out), .adr_stb,
    .fetch_n, .rd_n, .wr_n, .low_in(lo_in), .wr_addr, .wr_data);
  // second memory with no page latch: only its write address is watched
  emb_mem_model #(.HAS_PAGE(1'b0)) i_emb_mem_model_np (.clk, .low_out(lo_out), .low_oe(lo_oe),
    .high_out(hi_out), .adr_stb, .fetch_n, .rd_n, .wr_n, .low_in(), .wr_addr(np_addr), .wr_data());
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait for the answer pulse
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 40);
    if (done !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic do_reset(input logic s);
    @(negedge clk);
    rst_n = 1'b0;
    sel = s;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // strap read at reset, twice, once with each strap level, both with the bus idle
  task automatic s_boot();
    do_reset(1'b1);
    check(boot_ext, 1'b0);
    check(bvec, 16'h0000);
    check(gpio, 1'b1);
    check(busy, 1'b0);
    do_reset(1'b0);
    check(boot_ext, 1'b1);
    check(gpio, 1'b0);
  endtask
  task automatic s_fetch(input logic [15:0] a);
    @(negedge clk);
    freq = 1'b1;
    faddr = a;
    wait_done();
    freq = 1'b0;
    check(rdata, a[15:8] ^ a[7:0] ^ 8'hA5);
  endtask
  task automatic s_data(input logic w, input logic [23:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = a[23:16] + a[15:8] + a[7:0];
    @(negedge clk);
    dreq = 1'b1;
    dwr = w;
    daddr = a;
    wdata = d;
    wait_done();
    dreq = 1'b0;
    if (w) begin
      check(wr_addr, a);
      check(wr_data, d);
      check(np_addr, {8'h00, a[15:0]});
    end else check(rdata, e);
  endtask
  // both requests together: fetch first, data next
  task automatic s_both();
    @(negedge clk);
    freq = 1'b1;
    faddr = 16'h1234;
    dreq = 1'b1;
    dwr = 1'b0;
    daddr = 24'hABCDEF;
    wait_done();
    freq = 1'b0;
    check(rdata, 8'h83);
    wait_done();
    dreq = 1'b0;
    check(rdata, 8'h67);
  endtask
  // reset lands in the latch phase of a fetch, then a clean fetch follows
  task automatic s_cut();
    @(negedge clk);
    freq = 1'b1;
    faddr = 16'h4321;
    repeat (4) @(negedge clk);
    check({lo_oe, hi_oe, adr_stb}, 3'h7);
    freq = 1'b0;
    do_reset(1'b0);
    check({boot_ext, busy, lo_oe, hi_oe, adr_stb, fetch_n}, 6'h21);
    s_fetch(16'h4321);
  endtask
  initial begin
    s_boot();
    s_fetch(16'h0000);
    s_fetch(16'hFFFF);
    s_data(1'b1, 24'hFFFFFF, 8'h5A);
    s_data(1'b0, 24'hFFFFFF, 8'h00);
    s_data(1'b0, 24'h000000, 8'h00);
    s_data(1'b1, 24'h010203, 8'hC3);
    s_both();
    s_cut();
    print_verdict();
  end
endmodule // emb_bus_if_tb
